// ### rtl/sfc_pkg.sv
// Purpose: shared constants and types for the serial flash command front end
// Assumes: 256 KB array, 18-bit internal byte address
// Notes: opcodes, field positions, address masks and pin indices
`default_nettype none
package sfc_pkg;
  localparam int ADDR_W = 18;
  // opcodes
  localparam logic [7:0] CMD_ARRAY_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_ARRAY_READ = 8'h0B;
  localparam logic [7:0] CMD_DUAL_OUTPUT_READ = 8'h3B;
  localparam logic [7:0] CMD_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h81;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] CMD_FULL_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] CMD_SET_WRITE_LATCH = 8'h06;
  localparam logic [7:0] CMD_CLEAR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] CMD_VOLATILE_SR_ENABLE = 8'h50;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_CONFIG_READ = 8'h15;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_CONFIG_WRITE = 8'h11;
  localparam logic [7:0] CMD_ID_READ = 8'h9F;
  localparam logic [7:0] CMD_MAKER_DEVICE_READ = 8'h90;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] CMD_WAKE_AND_ID = 8'hAB;
  localparam logic [7:0] CMD_RESET_ARM = 8'h66;
  localparam logic [7:0] CMD_RESET_GO = 8'h99;
  // array organisation masks
  localparam logic [ADDR_W-1:0] ARR_TOP = 18'h3_FFFF;
  localparam logic [ADDR_W-1:0] TOP_SECT_BASE = 18'h3_F000;
  localparam logic [ADDR_W-1:0] PAGE_MASK = 18'h0_00FF;
  localparam logic [ADDR_W-1:0] SECT_MASK = 18'h0_0FFF;
  localparam logic [ADDR_W-1:0] MASK_8K = 18'h0_1FFF;
  localparam logic [ADDR_W-1:0] MASK_16K = 18'h0_3FFF;
  localparam logic [ADDR_W-1:0] HALF_MASK = 18'h0_7FFF;
  localparam logic [ADDR_W-1:0] FULL_MASK = 18'h0_FFFF;
  localparam logic [ADDR_W-1:0] MASK_128K = 18'h1_FFFF;
  // register fields
  localparam int CR_DC_BIT = 7;
  localparam int SR_SRP_BIT = 7;
  localparam int SR_BP_LO = 2;
  // framing counts
  localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;
  localparam logic [1:0] BYTES_SAT = 2'h2;
  localparam logic [3:0] DMY_CLK_SINGLE = 4'h8;
  localparam logic [3:0] DMY_CLK_DUAL_DC0 = 4'h4;
  localparam logic [3:0] DMY_CLK_DUAL_DC1 = 4'h8;
  localparam logic [2:0] OUT_FALLS_SINGLE = 3'h7;
  localparam logic [2:0] OUT_FALLS_DUAL = 3'h3;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  // synchronised pin vector
  localparam int PIN_CS = 0;
  localparam int PIN_CK = 1;
  localparam int PIN_LO = 2;
  localparam int PIN_HI = 3;
  localparam int PIN_WP = 4;
  localparam int PIN_N = 5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_DUMMY = 3'b010,
    ST_DIN = 3'b011, ST_DOUT = 3'b100, ST_STBY = 3'b101
  } sfc_state_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_PAGE_ERASE = 3'b001, OP_SECT_ERASE = 3'b010, OP_HALF_ERASE = 3'b011,
    OP_FULL_ERASE = 3'b100, OP_CHIP_ERASE = 3'b101, OP_PROG = 3'b110, OP_REG_WRITE = 3'b111
  } sfc_op_kind_t;

  typedef struct packed {
    sfc_op_kind_t kind;
    logic [ADDR_W-1:0] addr;
  } sfc_op_t;
endpackage
`default_nettype wire

// ### rtl/sfc_top.sv
// Purpose: serial flash command front end, device side, plus read-data fifo
// Assumes: clk_i 100 MHz, link pins asynchronous
// Notes: the array sits outside; reads and operations are requested
//
// Notes on behaviour
// [R1] erase or program on a protected range is dropped
// [R2] array is 4 KB sectors in 32/64 KB blocks, top sector 03F000H-03FFFFH
// [R3] bad opcode: standby until next select, outputs off
// [R4] good opcode: active until deselect
// [R5] inputs on clock rise, outputs on clock fall
// [R6] clock idles low or high, same edges
// [R7] reads may end after any bit, drivers released
// [R8] latch, register, erase, program, sleep, reset need byte-exact end
// [R9] while busy, array access is ignored
// [R10] dual reads make both data pins two-way
// [R11] 03h no dummy, 0Bh one dummy byte, both stream until deselect
// [R12] 3Bh, BBh: address, dummy, then two-line stream
// [R13] 81h, 20h, 52h erase with exactly three address bytes
// [R14] D8h erases 64 KB with address, 60h or C7h erase whole chip
// [R15] 06h sets write latch, 04h clears it, opcode only
// [R16] 50h lets next status write change the volatile copy
// [R17] 05h returns status, 15h configuration
// [R18] 01h writes status byte, 11h writes configuration byte
// [R19] 9Fh returns maker byte then two device bytes
// [R20] B9h sleeps, ABh with address wakes and returns id
// [R21] 90h with address repeats maker and device bytes
// [R22] host should poll status before commands
// [R23] latch clear refuses status write, program, erase
// [R24] busy bit is one while an operation runs
// [R25] dual output: high line odd bits, low line even, top pair first
`default_nettype none

module sfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // async reset, low
  input wire logic flush_i, // drop all entries
  input wire logic in_valid_i, // write side valid
  input wire logic [WIDTH-1:0] in_data_i, // write data
  output logic in_ready_o, // not full
  output logic out_valid_o, // not empty
  output logic [WIDTH-1:0] out_data_o, // head entry
  input wire logic out_ready_i // pop head
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
    logic vld;
  } sfc_fifo_state_t;

  sfc_fifo_state_t q, d;
  logic push, pop;

  // flush beats push and pop
  always_comb begin
    d = q;
    push = in_valid_i & q.rdy & ~flush_i;
    pop = out_ready_i & q.vld & ~flush_i;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    if (push & ~pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop & ~push) begin
      d.cnt = q.cnt - 1'b1;
    end
    if (flush_i) begin
      d.wp = '0;
      d.rp = '0;
      d.cnt = '0;
    end
    d.rdy = d.cnt != (AW + 1)'(DEPTH);
    d.vld = d.cnt != '0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1, vld: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign in_ready_o = q.rdy;
  assign out_valid_o = q.vld;
  assign out_data_o = q.mem[q.rp];
endmodule // sfc_fifo

module sfc_top
  import sfc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'hA5, // arbitrary value
  parameter logic [7:0] DEVICE_ID_HI = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_ID_LO = 8'h3C, // arbitrary value
  parameter logic [7:0] ELECTRONIC_ID = 8'hC3 // arbitrary value
) (
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // async reset, low
  input wire logic cs_n_i, // chip select pin, low
  input wire logic sclk_i, // serial clock pin
  input wire logic wp_n_i, // write protect pin, low
  input wire logic dual_line_low_i, // data in / line 0 in
  output logic dual_line_low_o, // line 0 out
  output logic dual_line_low_oe_o, // line 0 drive enable
  input wire logic dual_line_high_i, // line 1 in
  output logic dual_line_high_o, // data out / line 1 out
  output logic dual_line_high_oe_o, // line 1 drive enable
  input wire logic arr_valid_i, // array read byte valid
  input wire logic [7:0] arr_data_i, // array read byte
  output logic arr_ready_o, // fifo can take a byte
  output logic rd_go_o, // start array read stream
  output logic [ADDR_W-1:0] rd_addr_o, // read start address
  output logic rd_stop_o, // end array read stream
  output logic prog_wr_o, // program data byte strobe
  output logic [7:0] prog_data_o, // program data byte
  output logic op_go_o, // start array operation
  output sfc_op_t op_o, // operation kind and address
  input wire logic op_done_i, // operation finished
  output logic busy_flag_o, // operation running
  output logic write_enable_latch_o, // write latch state
  output logic active_o, // valid command in progress
  output logic sleep_o // deep power-down
);
  typedef struct packed {
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [PIN_N-1:0] s3;
    logic [PIN_N-1:0] lvl;
    sfc_state_t st;
    logic [7:0] cmd;
    logic [7:0] sh;
    logic [2:0] bitn;
    logic [1:0] acnt;
    logic [1:0] nbytes;
    logic [23:0] addr;
    logic [3:0] dmy;
    logic dual_in;
    logic dual_out;
    logic [7:0] obuf;
    logic [2:0] ocnt;
    logic [1:0] oidx;
    logic [7:0] wdat;
    logic srp;
    logic [4:0] bp;
    logic write_enable_latch;
    logic busy;
    logic dc;
    logic vol_en;
    logic sleep;
    logic rst_arm;
    logic act;
    logic lo_o;
    logic lo_oe;
    logic hi_o;
    logic hi_oe;
    logic rd_go;
    logic [ADDR_W-1:0] raddr;
    logic rd_stop;
    logic prog_wr;
    logic [7:0] pdat;
    logic op_go;
    sfc_op_t op;
    logic pop;
    logic flush;
  } sfc_top_state_t;

  sfc_top_state_t q, d;
  logic [PIN_N-1:0] pins, stab;
  logic f_vld;
  logic [7:0] f_dat;

  assign pins = {wp_n_i, dual_line_high_i, dual_line_low_i, sclk_i, cs_n_i};

  // level counts once stages two and three agree
  for (genvar i = 0; i < PIN_N; i++) begin : g_stab
    assign stab[i] = (q.s2[i] == q.s3[i]) ? q.s2[i] : q.lvl[i];
  end

  sfc_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(q.flush),
    .in_valid_i(arr_valid_i),
    .in_data_i(arr_data_i),
    .in_ready_o(arr_ready_o),
    .out_valid_o(f_vld),
    .out_data_o(f_dat),
    .out_ready_i(q.pop)
  );

  // command engine on stable pin levels
  always_comb begin
    logic ck_rise, ck_fall, cs_rise, cs_fall, cs_low;
    logic [7:0] b, nb;
    logic [2:0] step;
    logic byte_done, len_ok, need0, need1, wr_ok, pnone, hit, sr_unlk;
    logic [ADDR_W-1:0] pm, plo, phi, om, a, ostart, oend;
    logic [23:0] addr_nx;
    sfc_op_kind_t kind;
    ck_rise = stab[PIN_CK] & ~q.lvl[PIN_CK]; // R5 R6
    ck_fall = ~stab[PIN_CK] & q.lvl[PIN_CK]; // R5 R6
    cs_rise = stab[PIN_CS] & ~q.lvl[PIN_CS];
    cs_fall = ~stab[PIN_CS] & q.lvl[PIN_CS];
    cs_low = ~stab[PIN_CS];
    step = q.dual_in ? 3'h2 : 3'h1;
    b = q.dual_in ? {q.sh[5:0], stab[PIN_HI], stab[PIN_LO]} : {q.sh[6:0], stab[PIN_LO]};
    byte_done = (q.bitn + step) == 3'h0;
    addr_nx = {q.addr[15:0], b};
    len_ok = (q.st == ST_DIN) && (q.bitn == 3'h0); // R8
    need0 = q.nbytes == 2'h0;
    need1 = q.nbytes == 2'h1;
    wr_ok = q.write_enable_latch & ~q.busy; // R23 R9
    sr_unlk = ~q.srp | stab[PIN_WP];
    // protected range
    pnone = 1'b0;
    pm = ARR_TOP;
    if (!q.bp[4]) begin
      case (q.bp[1:0])
        2'h0: pnone = 1'b1;
        2'h1: pm = FULL_MASK;
        2'h2: pm = MASK_128K;
        default: pm = ARR_TOP;
      endcase
    end else begin
      case (q.bp[2:0])
        3'h0: pnone = 1'b1;
        3'h1: pm = SECT_MASK;
        3'h2: pm = MASK_8K;
        3'h3: pm = MASK_16K;
        3'h7: pm = ARR_TOP;
        default: pm = HALF_MASK;
      endcase
    end
    plo = q.bp[3] ? '0 : ARR_TOP - pm;
    phi = q.bp[3] ? pm : ARR_TOP;
    if (!q.bp[3] && pm == SECT_MASK) begin
      plo = TOP_SECT_BASE; // R2
    end
    // operation span, unit aligned
    case (q.cmd)
      CMD_PAGE_ERASE, CMD_PAGE_WRITE: om = PAGE_MASK;
      CMD_SECTOR_ERASE: om = SECT_MASK; // R2
      CMD_HALF_BLOCK_ERASE: om = HALF_MASK; // R2
      CMD_FULL_BLOCK_ERASE: om = FULL_MASK; // R2
      default: om = ARR_TOP;
    endcase
    a = q.addr[ADDR_W-1:0];
    ostart = a & ~om;
    oend = a | om;
    hit = ~pnone & (ostart <= phi) & (oend >= plo); // R1
    case (q.cmd)
      CMD_PAGE_ERASE: kind = OP_PAGE_ERASE;
      CMD_SECTOR_ERASE: kind = OP_SECT_ERASE;
      CMD_HALF_BLOCK_ERASE: kind = OP_HALF_ERASE;
      CMD_FULL_BLOCK_ERASE: kind = OP_FULL_ERASE;
      CMD_PAGE_WRITE: kind = OP_PROG;
      default: kind = OP_CHIP_ERASE;
    endcase
    // byte to send next
    case (q.cmd)
      CMD_STATUS_READ: nb = {q.srp, q.bp, q.write_enable_latch, q.busy}; // R17 R24
      CMD_CONFIG_READ: nb = {q.dc, 7'h00}; // R17
      CMD_ID_READ: nb = (q.oidx == 2'h0) ? MAKER_ID : (q.oidx == 2'h1) ? DEVICE_ID_HI : DEVICE_ID_LO; // R19
      CMD_MAKER_DEVICE_READ: nb = q.oidx[0] ? DEVICE_ID_LO : MAKER_ID; // R21
      CMD_WAKE_AND_ID: nb = ELECTRONIC_ID; // R20
      default: nb = f_vld ? f_dat : IDLE_BYTE; // R11
    endcase

    d = q;
    d.rd_go = 1'b0;
    d.rd_stop = 1'b0;
    d.prog_wr = 1'b0;
    d.op_go = 1'b0;
    d.pop = 1'b0;
    d.flush = 1'b0;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = stab;
    if (op_done_i) begin
      d.busy = 1'b0; // R24
      d.write_enable_latch = 1'b0;
    end
    if (cs_rise) begin
      // deselect ends all, pins released
      d.st = ST_IDLE;
      d.lo_oe = 1'b0; // R7 R3
      d.hi_oe = 1'b0; // R7 R3
      d.rd_stop = 1'b1;
      d.flush = 1'b1;
      d.rst_arm = 1'b0;
      if (q.cmd == CMD_WAKE_AND_ID && q.st == ST_DOUT) begin
        d.sleep = 1'b0; // R20
      end
      if (len_ok) begin
        case (q.cmd)
          CMD_SET_WRITE_LATCH: if (need0) d.write_enable_latch = 1'b1; // R15
          CMD_CLEAR_WRITE_LATCH: if (need0) d.write_enable_latch = 1'b0; // R15
          CMD_VOLATILE_SR_ENABLE: if (need0) d.vol_en = 1'b1; // R16
          CMD_DEEP_SLEEP: if (need0) d.sleep = 1'b1; // R20
          CMD_RESET_ARM: if (need0) d.rst_arm = 1'b1;
          CMD_RESET_GO: begin
            if (need0 && q.rst_arm && !q.busy) begin
              d.write_enable_latch = 1'b0;
              d.vol_en = 1'b0;
            end
          end
          CMD_STATUS_WRITE: begin
            d.vol_en = 1'b0;
            if (need1 && q.vol_en && !q.busy) begin
              {d.srp, d.bp} = q.wdat[SR_SRP_BIT:SR_BP_LO]; // R16 R18
            end else if (need1 && wr_ok && sr_unlk) begin
              {d.srp, d.bp} = q.wdat[SR_SRP_BIT:SR_BP_LO]; // R18
              d.op_go = 1'b1;
              d.op = '{kind: OP_REG_WRITE, addr: '0};
              d.busy = 1'b1; // R24
            end
          end
          CMD_CONFIG_WRITE: begin
            if (need1 && wr_ok) begin
              d.dc = q.wdat[CR_DC_BIT]; // R18
              d.op_go = 1'b1;
              d.op = '{kind: OP_REG_WRITE, addr: '0};
              d.busy = 1'b1; // R24
            end
          end
          CMD_PAGE_ERASE, CMD_SECTOR_ERASE, CMD_HALF_BLOCK_ERASE, CMD_FULL_BLOCK_ERASE,
          CMD_CHIP_ERASE_A, CMD_CHIP_ERASE_B, CMD_PAGE_WRITE: begin
            // R13 R14
            if (((q.cmd == CMD_PAGE_WRITE) ? !need0 : need0) && wr_ok && !hit) begin // R1
              d.op_go = 1'b1;
              d.op = '{kind: kind, addr: ostart};
              d.busy = 1'b1; // R24
            end
          end
          default: ;
        endcase
      end
    end else if (cs_fall) begin
      d.st = ST_IDLE;
      d.bitn = 3'h0;
      d.nbytes = 2'h0;
      d.acnt = 2'h0;
      d.ocnt = 3'h0;
      d.oidx = 2'h0;
      d.dual_in = 1'b0;
      d.dual_out = 1'b0;
    end else if (cs_low && ck_rise) begin
      d.sh = b; // R5
      d.bitn = q.bitn + step;
      case (q.st)
        ST_IDLE: begin
          if (byte_done) begin
            d.cmd = b;
            if (q.sleep && b != CMD_WAKE_AND_ID) begin
              d.st = ST_STBY; // R20
            end else begin
              case (b)
                CMD_ARRAY_READ, CMD_FAST_ARRAY_READ, CMD_DUAL_OUTPUT_READ, CMD_DUAL_IO_READ: begin
                  d.st = q.busy ? ST_STBY : ST_ADDR; // R9
                  d.dual_in = b == CMD_DUAL_IO_READ; // R10
                end
                CMD_PAGE_ERASE, CMD_SECTOR_ERASE, CMD_HALF_BLOCK_ERASE, CMD_FULL_BLOCK_ERASE,
                CMD_PAGE_WRITE, CMD_MAKER_DEVICE_READ, CMD_WAKE_AND_ID: d.st = ST_ADDR; // R4
                CMD_SET_WRITE_LATCH, CMD_CLEAR_WRITE_LATCH, CMD_VOLATILE_SR_ENABLE, CMD_CHIP_ERASE_A,
                CMD_CHIP_ERASE_B, CMD_STATUS_WRITE, CMD_CONFIG_WRITE, CMD_DEEP_SLEEP, CMD_RESET_ARM,
                CMD_RESET_GO: d.st = ST_DIN; // R4
                CMD_STATUS_READ, CMD_CONFIG_READ, CMD_ID_READ: d.st = ST_DOUT; // R4
                default: d.st = ST_STBY; // R3
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            d.addr = addr_nx;
            d.acnt = q.acnt + 2'h1;
            if (q.acnt == ADDR_BYTES_LAST) begin
              d.raddr = addr_nx[ADDR_W-1:0];
              case (q.cmd)
                CMD_ARRAY_READ: begin
                  d.st = ST_DOUT; // R11
                  d.rd_go = 1'b1;
                  d.flush = 1'b1;
                end
                CMD_FAST_ARRAY_READ, CMD_DUAL_OUTPUT_READ: begin
                  d.st = ST_DUMMY; // R11 R12
                  d.dmy = DMY_CLK_SINGLE;
                  d.dual_out = q.cmd == CMD_DUAL_OUTPUT_READ; // R10
                  d.rd_go = 1'b1;
                  d.flush = 1'b1;
                end
                CMD_DUAL_IO_READ: begin
                  d.st = ST_DUMMY; // R12
                  d.dmy = q.dc ? DMY_CLK_DUAL_DC1 : DMY_CLK_DUAL_DC0;
                  d.dual_in = 1'b0;
                  d.dual_out = 1'b1; // R10
                  d.rd_go = 1'b1;
                  d.flush = 1'b1;
                end
                CMD_MAKER_DEVICE_READ, CMD_WAKE_AND_ID: d.st = ST_DOUT; // R20 R21
                default: d.st = ST_DIN; // R13 R14
              endcase
            end
          end
        end
        ST_DUMMY: begin
          d.dmy = q.dmy - 4'h1;
          if (q.dmy == 4'h1) begin
            d.st = ST_DOUT;
          end
        end
        ST_DIN: begin
          if (byte_done) begin
            d.nbytes = (q.nbytes == BYTES_SAT) ? q.nbytes : q.nbytes + 2'h1;
            d.wdat = b;
            if (q.cmd == CMD_PAGE_WRITE && wr_ok) begin
              d.prog_wr = 1'b1; // R9 R23
              d.pdat = b;
            end
          end
        end
        default: ;
      endcase
    end else if (cs_low && ck_fall && q.st == ST_DOUT) begin
      // bits leave on the fall; odd bits on high line
      if (q.ocnt == 3'h0) begin
        d.hi_o = nb[7]; // R25
        d.lo_o = nb[6]; // R25
        d.obuf = q.dual_out ? (nb << 2) : (nb << 1);
        d.ocnt = q.dual_out ? OUT_FALLS_DUAL : OUT_FALLS_SINGLE;
        d.hi_oe = 1'b1; // R5
        d.lo_oe = q.dual_out; // R10
        d.oidx = (q.cmd == CMD_ID_READ && q.oidx == 2'h2) ? 2'h0 : q.oidx + 2'h1;
        d.pop = f_vld && (q.cmd == CMD_ARRAY_READ || q.cmd == CMD_FAST_ARRAY_READ ||
                          q.cmd == CMD_DUAL_OUTPUT_READ || q.cmd == CMD_DUAL_IO_READ);
      end else begin
        d.hi_o = q.obuf[7]; // R5 R25
        d.lo_o = q.obuf[6];
        d.obuf = q.dual_out ? (q.obuf << 2) : (q.obuf << 1);
        d.ocnt = q.ocnt - 3'h1;
      end
    end
    d.act = cs_low && d.st != ST_STBY && d.st != ST_IDLE; // R4
  end

  // cs starts high so reset is no select
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.s1 <= 5'h1_F;
      q.s2 <= 5'h1_F;
      q.s3 <= 5'h1_F;
      q.lvl <= 5'h1_F;
    end else begin
      q <= d;
    end
  end

  assign dual_line_low_o = q.lo_o;
  assign dual_line_low_oe_o = q.lo_oe;
  assign dual_line_high_o = q.hi_o;
  assign dual_line_high_oe_o = q.hi_oe;
  assign rd_go_o = q.rd_go;
  assign rd_addr_o = q.raddr;
  assign rd_stop_o = q.rd_stop;
  assign prog_wr_o = q.prog_wr;
  assign prog_data_o = q.pdat;
  assign op_go_o = q.op_go;
  assign op_o = q.op;
  assign busy_flag_o = q.busy;
  assign write_enable_latch_o = q.write_enable_latch;
  assign active_o = q.act;
  assign sleep_o = q.sleep;
endmodule // sfc_top
`default_nettype wire

// ### test/sfc_monitor.sv
// Purpose: port checks for the flash command front end
// Assumes: link pins pass a 3-flop sync chain
// Notes: 6-cycle windows cover the sync chain plus the output flop
`default_nettype none
module sfc_monitor
  import sfc_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_n_i, // reset, low
  input wire logic cs_n_i, // select, low
  input wire logic sclk_i, // link clock
  input wire logic op_done_i, // op finished
  input wire logic dual_line_low_oe_o, // line 0 drive
  input wire logic dual_line_high_o, // line 1 out
  input wire logic dual_line_high_oe_o, // line 1 drive
  input wire logic rd_go_o, // read start
  input wire logic op_go_o, // op start
  input wire sfc_op_t op_o, // op kind, addr
  input wire logic busy_flag_o, // busy
  input wire logic write_enable_latch_o, // latch
  input wire logic active_o, // active
  input wire logic sleep_o // asleep
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // drivers and activity end with the select
  a_oe_off_idle: assert property (cs_n_i [*6] |-> !dual_line_high_oe_o && !dual_line_low_oe_o)
    else $error("line driven while deselected");
  a_idle_inactive: assert property (cs_n_i [*6] |-> !active_o)
    else $error("active while deselected");
  // operation start and end
  a_go_busy: assert property (op_go_o |=> busy_flag_o)
    else $error("busy missing after start");
  a_done_clear: assert property (
    busy_flag_o && op_done_i && !op_go_o |=> !busy_flag_o && !write_enable_latch_o)
    else $error("busy or latch kept after done");
  a_go_latch: assert property (op_go_o |-> write_enable_latch_o && !$past(busy_flag_o))
    else $error("start without latch or while busy");
  a_go_deselect: assert property (op_go_o |-> $past(cs_n_i, 2))
    else $error("start before deselect");
  a_read_ready: assert property (rd_go_o |-> !busy_flag_o && !sleep_o && !cs_n_i)
    else $error("read started while busy or asleep");
  a_erase_align: assert property (op_go_o |-> (
    (op_o.kind != OP_SECT_ERASE || (op_o.addr & SECT_MASK) == '0) &&
    (op_o.kind != OP_HALF_ERASE || (op_o.addr & HALF_MASK) == '0) &&
    (op_o.kind != OP_FULL_ERASE || (op_o.addr & FULL_MASK) == '0)))
    else $error("erase start not aligned");
  // output moves only after a link clock fall
  a_out_on_fall: assert property (
    dual_line_high_oe_o && $past(dual_line_high_oe_o) && $changed(dual_line_high_o) |-> !$past(sclk_i, 2))
    else $error("output changed with clock high");
  a_dual_pair: assert property (dual_line_low_oe_o |-> dual_line_high_oe_o)
    else $error("line 0 driven alone");
  c_op: cover property (op_go_o);
  c_read: cover property (rd_go_o);
  c_sleep: cover property ($rose(sleep_o));
endmodule // sfc_monitor
bind sfc_top sfc_monitor mon (.*);
`default_nettype wire

// ### test/sfc_host.sv
// Purpose: host model driving select, link clock and data
// Assumes: 80 ns link clock, edges 1 ns after a core edge
// Notes: data line flips when released so a stale level never reads back
`default_nettype none
module sfc_host (
  input wire logic clk_i, // core clock
  input wire logic so_i, // line 1 wire level
  output logic cs_n_o, // select, low
  output logic sclk_o, // link clock
  output logic si_o, // line 0 data
  output logic rx_tgl_o, // flips per byte read
  output logic [7:0] rx_o // byte read
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cpol = 1'b0; // idle level of link clock
  // idle pins
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
    rx_tgl_o = 1'b0;
    rx_o = 8'h00;
  end
  // one select: ntx bits out msb first, then nrx whole bytes in
  task automatic frame(input logic [63:0] tx, input int ntx, input int nrx);
    int i;
    @(posedge clk_i);
    #1;
    sclk_o = cpol;
    cs_n_o = 1'b0;
    #40;
    for (i = 0; i < ntx + 8 * nrx; i++) begin
      sclk_o = 1'b0;
      if (i < ntx) si_o = tx[63-i];
      #40;
      sclk_o = 1'b1;
      rx_o = {rx_o[6:0], so_i};
      if (i >= ntx && (i - ntx) % 8 == 7) rx_tgl_o = ~rx_tgl_o;
      #40;
    end
    sclk_o = cpol;
    #40;
    cs_n_o = 1'b1;
    si_o = ~si_o;
    #160;
  endtask
endmodule // sfc_host
`default_nettype wire

// ### test/sfc_top_bench.sv
// Purpose: self-checking bench for the flash command front end
// Assumes: 100 MHz core clock, host model at 80 ns link clock
// Notes: every result is checked in order against a queue of notes
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin fail_count++; $display("wrong value %s exp %h got %h", n, e, s); end end
module sfc_top_bench import sfc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_n_i = 1'b0, arr_valid_i = 1'b0, op_done_i = 1'b0, tog = 1'b0;
  logic [7:0] arr_data_i = 8'h00;
  logic cs_n, sclk, si, rx_tgl, lo_o, lo_oe, hi_o, hi_oe, arr_ready_o, rd_go_o, op_go_o;
  logic [7:0] rx;
  logic [17:0] rd_addr_o;
  sfc_op_t op_o;
  int fail_count = 0, n_checks = 0, seed = 62268, n;
  logic [23:0] exp_q[$];
  logic [23:0] hold_v;
  logic [7:0] idv[6] = '{8'hA5, 8'h5A, 8'h3C, 8'hA5, 8'h3C, 8'hC3};
  wire logic hi_w = hi_oe ? hi_o : tog; // released line changes every cycle
  wire logic lo_w = lo_oe ? lo_o : si;
  // clock, toggle for released lines
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) tog <= ~tog;
  sfc_top dut (.*, .cs_n_i(cs_n), .sclk_i(sclk), .wp_n_i(1'b1),
    .dual_line_low_i(lo_w), .dual_line_low_o(lo_o), .dual_line_low_oe_o(lo_oe),
    .dual_line_high_i(hi_w), .dual_line_high_o(hi_o), .dual_line_high_oe_o(hi_oe), .rd_stop_o(),
    .prog_wr_o(), .prog_data_o(), .busy_flag_o(), .write_enable_latch_o(), .active_o(), .sleep_o());
  sfc_host host (.clk_i, .so_i(hi_w), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .rx_tgl_o(rx_tgl), .rx_o(rx));
  // oldest note per result; empty queue gives x
  task automatic got(input logic [23:0] v);
    hold_v = exp_q.size() ? exp_q.pop_front() : 24'hxx_xxxx;
    `CHK("result", hold_v, v)
  endtask
  always @(rx_tgl) if ($time > 0) got({16'h0000, rx});
  always @(posedge clk_i) begin
    if (op_go_o === 1'b1) got({3'h1, op_o});
    if (rd_go_o === 1'b1) got({6'h10, rd_addr_o});
  end
  task automatic status(input logic [7:0] e);
    exp_q.push_back({16'h0000, e});
    host.frame({CMD_STATUS_READ, 56'h0}, 8, 1);
  endtask
  task automatic op1(input logic [7:0] c);
    host.frame({c, 56'h0}, 8, 0);
  endtask
  // array fills buffer until refused
  task automatic fill();
    @(posedge rd_go_o);
    @(posedge clk_i); // flush pulse still high here
    #1;
    n = 0;
    while (arr_ready_o === 1'b1) begin
      arr_valid_i = 1'b1;
      arr_data_i = 8'($random(seed));
      exp_q.push_back({16'h0000, arr_data_i});
      n++;
      @(posedge clk_i);
      #1;
    end
    arr_data_i = 8'($random(seed));
    repeat (3) @(posedge clk_i);
    #1;
    arr_valid_i = 1'b0;
    `CHK("fill count", 16, n)
    exp_q.push_back(24'h00_00FF);
  endtask
  task automatic stop_test();
    `CHK("pending notes", 0, exp_q.size())
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #300_000;
    fail_count++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    status(8'h00);
    op1(8'h4B);
    host.cpol = 1'b1;
    op1(CMD_SET_WRITE_LATCH);
    status(8'h02);
    op1(CMD_CLEAR_WRITE_LATCH);
    host.frame({CMD_SET_WRITE_LATCH, 56'h0}, 9, 0);
    status(8'h00);
    host.frame({CMD_SECTOR_ERASE, 24'h03_F123, 32'h0}, 32, 0);
    op1(CMD_SET_WRITE_LATCH);
    exp_q.push_back({3'h1, OP_SECT_ERASE, 18'h3_F000});
    host.frame({CMD_SECTOR_ERASE, 24'h03_F123, 32'h0}, 32, 0);
    status(8'h03);
    host.frame({CMD_ARRAY_READ, 24'h00_0000, 32'h0}, 32, 0);
    op_done_i = 1'b1;
    @(posedge clk_i);
    #1;
    op_done_i = 1'b0;
    status(8'h00);
    op1(CMD_VOLATILE_SR_ENABLE);
    host.frame({CMD_STATUS_WRITE, 8'h0C, 48'h0}, 16, 0);
    op1(CMD_SET_WRITE_LATCH);
    host.frame({CMD_FULL_BLOCK_ERASE, 24'h00_0000, 32'h0}, 32, 0);
    op1(CMD_CHIP_ERASE_B);
    status(8'h0E);
    foreach (idv[i]) exp_q.push_back({16'h0000, idv[i]});
    host.frame({CMD_ID_READ, 56'h0}, 8, 3);
    host.frame({CMD_MAKER_DEVICE_READ, 24'h00_0000, 32'h0}, 32, 2);
    op1(CMD_DEEP_SLEEP);
    op1(CMD_STATUS_READ);
    host.frame({CMD_WAKE_AND_ID, 24'h00_0000, 32'h0}, 32, 1);
    host.cpol = 1'b0;
    exp_q.push_back({6'h10, 18'h2_3456});
    fork
      host.frame({CMD_FAST_ARRAY_READ, 24'h12_3456, 32'h0}, 40, 17);
      fill();
    join
    exp_q.push_back({6'h10, 18'h0_0100});
    host.frame({CMD_DUAL_OUTPUT_READ, 24'h00_0100, 32'h0}, 48, 0);
    stop_test();
  end
endmodule // sfc_top_bench
`default_nettype wire
